// [core/irb_pkg.sv]
// Constants and types shared by the identification register bank
package irb_pkg;

   // Register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Word offsets of the identification and control registers
   localparam logic [ADDR_W-1:0] OFF_FWD_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_FWD_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_IDENT_REVISION_WORD = 12'hFEC;
   localparam logic [ADDR_W-1:0] OFF_COMPONENT_IDENT_BYTE0 = 12'hFF0;
   localparam logic [ADDR_W-1:0] OFF_COMPONENT_IDENT_BYTE1 = 12'hFF4;
   localparam logic [ADDR_W-1:0] OFF_COMPONENT_IDENT_BYTE2 = 12'hFF8;
   localparam logic [ADDR_W-1:0] OFF_COMPONENT_IDENT_BYTE3 = 12'hFFC;

   // Field layout of the revision word
   localparam int FIX_LEVEL_LSB = 4;
   localparam int FIX_LEVEL_W = 4;
   localparam int MOD_FIELD_LSB = 0;
   localparam int MOD_FIELD_W = 4;
   localparam int IDENT_BYTE_W = 8;

   // Modification field value (arbitrary)
   localparam logic [MOD_FIELD_W-1:0] MOD_FIELD_VALUE = 4'h1;
   // Component identity value (arbitrary)
   localparam logic [DATA_W-1:0] COMPONENT_IDENT_VALUE = 32'h5A3C9E71;

   // Filter units and forwarded signal width
   localparam int NUM_FILTER_UNITS = 4;
   localparam int FWD_W = 8;

   // Reset values
   localparam logic [NUM_FILTER_UNITS-1:0] FWD_CTRL_RESET = 4'hF;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

   // Read source selection
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_REV,
      SEL_COMPONENT_IDENT_BYTE0,
      SEL_COMPONENT_IDENT_BYTE1,
      SEL_COMPONENT_IDENT_BYTE2,
      SEL_COMPONENT_IDENT_BYTE3,
      SEL_CTRL,
      SEL_STATUS
   } irb_sel_t;

endpackage

// [core/irb_rd_if.sv]
// Read request and answer between the bank and its identity store
`timescale 1ns/1ps
`default_nettype none

interface irb_rd_if;
   import irb_pkg::*;

   logic rd_en;
   irb_sel_t sel;
   logic [FIX_LEVEL_W-1:0] fix_level;
   logic [NUM_FILTER_UNITS-1:0] fwd_enable;
   logic [DATA_W-1:0] rdata;

   modport bank (output rd_en, output sel, output fix_level, output fwd_enable, input rdata);
   modport store (input rd_en, input sel, input fix_level, input fwd_enable, output rdata);

endinterface

`default_nettype wire

// [core/irb_ident_store.sv]
// Identity word store with registered read data
`timescale 1ns/1ps
`default_nettype none

module irb_ident_store
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   irb_rd_if.store rd
);

   // Pick one byte of the component identity, low byte first
   function automatic logic [DATA_W-1:0] ident_byte(input logic [1:0] idx);
      logic [DATA_W-1:0] word;
      word = '0;
      word[IDENT_BYTE_W-1:0] = COMPONENT_IDENT_VALUE[idx*IDENT_BYTE_W +: IDENT_BYTE_W];
      return word;
   endfunction

   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] rdata_reg;

   // Read word assembly; upper bits stay zero
   always_comb begin
      rdata_next = '0;
      if (rd.rd_en) begin
         case (rd.sel)
            SEL_REV: begin
               rdata_next[FIX_LEVEL_LSB +: FIX_LEVEL_W] = rd.fix_level;
               rdata_next[MOD_FIELD_LSB +: MOD_FIELD_W] = MOD_FIELD_VALUE;
            end
            SEL_COMPONENT_IDENT_BYTE0: rdata_next = ident_byte(2'h0);
            SEL_COMPONENT_IDENT_BYTE1: rdata_next = ident_byte(2'h1);
            SEL_COMPONENT_IDENT_BYTE2: rdata_next = ident_byte(2'h2);
            SEL_COMPONENT_IDENT_BYTE3: rdata_next = ident_byte(2'h3);
            SEL_CTRL: rdata_next[NUM_FILTER_UNITS-1:0] = rd.fwd_enable;
            SEL_STATUS: rdata_next[FIX_LEVEL_W-1:0] = rd.fix_level;
            default: rdata_next = '0;
         endcase
      end
   end

   // Data stand one cycle for each cycle of the read strobe, zero otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rd.rdata = rdata_reg;

endmodule

`default_nettype wire

// [core/irb_ident_bank.sv]
// Identification register bank with per-unit signal forwarding
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none

module irb_ident_bank
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [FIX_LEVEL_W-1:0] fix_level_tieoff_input,
   input wire logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_slave_side,
   output logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_master_side
);

   // Map a word address to its read source
   function automatic irb_sel_t addr_decode(input logic [ADDR_W-1:0] addr);
      irb_sel_t sel;
      sel = SEL_NONE;
      if (addr == OFF_IDENT_REVISION_WORD) begin
         sel = SEL_REV;
      end else if (addr == OFF_COMPONENT_IDENT_BYTE0) begin
         sel = SEL_COMPONENT_IDENT_BYTE0;
      end else if (addr == OFF_COMPONENT_IDENT_BYTE1) begin
         sel = SEL_COMPONENT_IDENT_BYTE1;
      end else if (addr == OFF_COMPONENT_IDENT_BYTE2) begin
         sel = SEL_COMPONENT_IDENT_BYTE2;
      end else if (addr == OFF_COMPONENT_IDENT_BYTE3) begin
         sel = SEL_COMPONENT_IDENT_BYTE3;
      end else if (addr == OFF_FWD_CTRL) begin
         sel = SEL_CTRL;
      end else if (addr == OFF_FWD_STATUS) begin
         sel = SEL_STATUS;
      end
      return sel;
   endfunction

   irb_rd_if rd_bus ();

   logic [FIX_LEVEL_W-1:0] fix_meta_reg;
   logic [FIX_LEVEL_W-1:0] fix_sync_reg;
   logic [NUM_FILTER_UNITS-1:0] fwd_enable_reg;
   logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_out_reg;
   irb_sel_t wr_sel;

   // Tie-off enters from outside the clock; two stages before use
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fix_meta_reg <= '0;
         fix_sync_reg <= '0;
      end else begin
         fix_meta_reg <= fix_level_tieoff_input;
         // Only this stage feeds the read path
         fix_sync_reg <= fix_meta_reg;
      end
   end

   assign wr_sel = addr_decode(reg_addr);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fwd_enable_reg <= FWD_CTRL_RESET;
      end else if (reg_wr && wr_sel == SEL_CTRL) begin
         fwd_enable_reg <= reg_wdata[NUM_FILTER_UNITS-1:0];
      end
   end

   for (genvar u = 0; u < NUM_FILTER_UNITS; u++) begin : g_unit
      // slave side in, master side out
      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            fwd_out_reg[u] <= '0;
         end else if (fwd_enable_reg[u]) begin
            fwd_out_reg[u] <= fwd_slave_side[u];
         end else begin
            fwd_out_reg[u] <= '0;
         end
      end
   end

   // identity bytes served by the store
   assign rd_bus.rd_en = reg_rd;
   assign rd_bus.sel = addr_decode(reg_addr);
   assign rd_bus.fix_level = fix_sync_reg;
   assign rd_bus.fwd_enable = fwd_enable_reg;

   irb_ident_store u_store (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .rd(rd_bus.store)
   );

   // Outputs come straight from registers
   assign reg_rdata = rd_bus.rdata;
   assign fwd_master_side = fwd_out_reg;

endmodule

`default_nettype wire

// [sim/irb_chk_props.sv]
// Port checker of the identification bank
`timescale 1ns/1ps
`default_nettype none
module irb_chk
   import irb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [FIX_LEVEL_W-1:0] fix_level_tieoff_input,
   input wire logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_slave_side,
   input wire logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_master_side
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Tie-off must be settled through the synchroniser first
   property p_rev;
      $past(rst_b, 3) && fix_level_tieoff_input == $past(fix_level_tieoff_input)
      && fix_level_tieoff_input == $past(fix_level_tieoff_input, 2) && reg_rd && reg_addr == OFF_IDENT_REVISION_WORD
      |=> reg_rdata[7:4] == $past(fix_level_tieoff_input);
   endproperty
   property p_mod;
      reg_rd && reg_addr == OFF_IDENT_REVISION_WORD |=> reg_rdata[31:8] == 24'h000000 && reg_rdata[3:0] == MOD_FIELD_VALUE;
   endproperty
   // Byte lane picked by word offset, lowest first
   property p_cid;
      reg_rd && reg_addr[11:4] == 8'hFF && reg_addr[1:0] == 2'h0
      |=> reg_rdata == {24'h000000, COMPONENT_IDENT_VALUE[8 * $past(reg_addr[3:2]) +: 8]};
   endproperty
   property p_idle;
      !reg_rd |=> reg_rdata == 32'h00000000;
   endproperty
   property p_wr;
      reg_wr ##1 !reg_rd |=> reg_rdata == 32'h00000000;
   endproperty
   // Disabled unit shows zero instead of the sample
   property p_fwd(int u);
      fwd_master_side[u] == $past(fwd_slave_side[u]) || fwd_master_side[u] == 8'h00;
   endproperty
   a_rev: assert property (p_rev) else $error("revision field wrong");
   a_mod: assert property (p_mod) else $error("revision word fixed bits wrong");
   a_cid: assert property (p_cid) else $error("identity byte wrong");
   a_idle: assert property (p_idle) else $error("read data not cleared");
   a_wr: assert property (p_wr) else $error("write produced read data");
   for (genvar u = 0; u < NUM_FILTER_UNITS; u++) begin : g_unit
      a_fwd: assert property (p_fwd(u)) else $error("forwarded copy wrong");
   end
   c_rev: cover property (reg_rd && reg_addr == OFF_IDENT_REVISION_WORD && fix_level_tieoff_input != 4'h0);
   c_cid: cover property (reg_rd && reg_addr == OFF_COMPONENT_IDENT_BYTE3);
   c_wr: cover property (reg_wr && reg_addr[11:4] == 8'hFF);
endmodule
bind irb_ident_bank irb_chk i_irb_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_level_tieoff_input(fix_level_tieoff_input),
   .fwd_slave_side(fwd_slave_side), .fwd_master_side(fwd_master_side));
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the identification bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import irb_pkg::*;
;
   logic core_clk, rst_b, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [FIX_LEVEL_W-1:0] fix_lvl;
   logic [NUM_FILTER_UNITS-1:0][FWD_W-1:0] fwd_s, fwd_m;
   logic [43:0] rows [6];
   int num_errors = 0;
   int tests_run = 0;
   irb_ident_bank i_irb_ident_bank (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_level_tieoff_input(fix_lvl),
      .fwd_slave_side(fwd_s), .fwd_master_side(fwd_m));
   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Read answer stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard at 2500 cycles, far beyond the fewer than 40 cycles needed
   initial begin
      #100us;
      num_errors++;
      close_out;
   end
   initial begin
      rows = '{{OFF_IDENT_REVISION_WORD, 24'h0, 4'h0, MOD_FIELD_VALUE},
         {OFF_COMPONENT_IDENT_BYTE0, 24'h0, COMPONENT_IDENT_VALUE[7:0]},
         {OFF_COMPONENT_IDENT_BYTE1, 24'h0, COMPONENT_IDENT_VALUE[15:8]},
         {OFF_COMPONENT_IDENT_BYTE2, 24'h0, COMPONENT_IDENT_VALUE[23:16]},
         {OFF_COMPONENT_IDENT_BYTE3, 24'h0, COMPONENT_IDENT_VALUE[31:24]}, {12'h800, 32'h0}};
      {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, fix_lvl, fwd_s} = '0;
      repeat (4) @(posedge core_clk);
      chk(fwd_m, 32'h0);
      rst_b <= 1'b1;
      foreach (rows[i]) rd(rows[i][43:32], rows[i][31:0]);
      // Identity words ignore writes
      wr(OFF_COMPONENT_IDENT_BYTE0, 32'hFFFFFFFF);
      wr(OFF_IDENT_REVISION_WORD, 32'hFFFFFFFF);
      rd(OFF_COMPONENT_IDENT_BYTE0, {24'h0, COMPONENT_IDENT_VALUE[7:0]});
      // Tie-off change reaches the revision field after the synchroniser
      @(posedge core_clk);
      fix_lvl <= 4'hA;
      repeat (3) @(posedge core_clk);
      rd(OFF_IDENT_REVISION_WORD, {24'h0, 4'hA, MOD_FIELD_VALUE});
      rd(OFF_FWD_STATUS, 32'h0000000A);
      @(posedge core_clk);
      fwd_s <= 32'h443322AB;
      @(posedge core_clk);
      #1 chk(fwd_m, 32'h443322AB);
      // Units 1 and 3 switched off, others keep forwarding
      wr(OFF_FWD_CTRL, 32'h5);
      @(posedge core_clk);
      #1 chk(fwd_m, 32'h003300AB);
      rd(OFF_FWD_CTRL, 32'h00000005);
      close_out;
   end
endmodule
`default_nettype wire
